//--- design/bec_capture.sv
// The implementer's own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ns
`include "bec_cfg.svh"
module bec_capture (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // error report, one-cycle pulse with its qualifiers
  input  wire logic        err_valid,
  input  wire logic [5:0]  err_type,
  // bus interface unit details
  input  wire logic [3:0]  unit_subcode,
  input  wire logic [7:0]  unit_axi_id,
  input  wire logic [3:0]  unit_axi_resp,
  input  wire logic        unit_entry_lock,
  input  wire logic [4:0]  requesting_thread_number,
  input  wire logic [3:0]  unit_req_port,
  input  wire logic        unit_entry_write,
  input  wire logic        unit_entry_uca,
  input  wire logic        entry_uncached_flag,
  // ring bus details
  input  wire logic        ring_pkt_write,
  input  wire logic        ring_endpoint_off,
  input  wire logic        ring_unclaimed,
  input  wire logic        ring_byte_enable_err,
  input  wire logic        ring_parity_err,
  // interrupt
  output logic             irq
);
  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  function automatic logic is_rdb_sub(input logic [3:0] s);
    is_rdb_sub = (s <= 4'h3) || (s == 4'h6) || (s == 4'h8) || (s == 4'h9);
  endfunction : is_rdb_sub

  function automatic logic is_axi_sub(input logic [3:0] s);
    is_axi_sub = (s == 4'h1) || (s == 4'h3) || (s == 4'h4) || (s == 4'h5);
  endfunction : is_axi_sub

  function automatic logic [31:0] lane_merge(input logic [31:0] o,
                                             input logic [31:0] n,
                                             input logic [3:0]  st);
    logic [31:0] m;
    m = {{8{st[3]}}, {8{st[2]}}, {8{st[1]}}, {8{st[0]}}};
    lane_merge = (o & ~m) | (n & m);
  endfunction : lane_merge

  // ----------------------------------------
  // state
  // ----------------------------------------
  bec_pkg::bec_detail_t detail_q, detail_d;
  logic [5:0]  type_q;
  logic [1:0]  status_q, status_d;
  logic [1:0]  mask_q, mask_d;
  logic        ctrl_q, ctrl_d;
  logic        aw_got_q, w_got_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        bvalid_q, rvalid_q;
  logic [1:0]  bresp_q, rresp_q;
  logic [31:0] rdata_q;

  // ----------------------------------------
  // error classification
  // ----------------------------------------
  wire type_unit = (err_type >= `BEC_TYPE_UNIT_LO) && (err_type <= `BEC_TYPE_UNIT_HI);
  wire type_ring = (err_type == `BEC_TYPE_RING);
  wire cap_unit  = err_valid && ctrl_q && type_unit;
  wire cap_ring  = err_valid && ctrl_q && type_ring;
  wire axi_ok    = is_axi_sub(unit_subcode) && (err_type == `BEC_TYPE_AXI_CAP);
  wire rdb_ok    = is_rdb_sub(unit_subcode);

  // ----------------------------------------
  // bus interface unit layout
  // ----------------------------------------
  // port codes 10..15 pass straight through; the field is only 4 bits wide
  bec_pkg::bec_detail_t unit_fmt;
  always_comb begin
    unit_fmt = '0;
    unit_fmt[`BEC_SUB_HI:`BEC_SUB_LO] = unit_subcode;
    if (axi_ok) begin
      unit_fmt[`BEC_AXID_HI:`BEC_AXID_LO] = unit_axi_id;
      unit_fmt[`BEC_RESP_HI:`BEC_RESP_LO] = unit_axi_resp;
    end
    if (rdb_ok) begin
      unit_fmt[`BEC_LOCK_BIT]             = unit_entry_lock;
      unit_fmt[`BEC_THRD_HI:`BEC_THRD_LO] = requesting_thread_number;
      unit_fmt[`BEC_PORT_HI:`BEC_PORT_LO] = unit_req_port;
      unit_fmt[`BEC_WR_BIT]               = unit_entry_write;
      unit_fmt[`BEC_UCA_BIT]              = unit_entry_uca;
      unit_fmt[`BEC_UC_BIT]               = entry_uncached_flag;
    end
  end

  // ----------------------------------------
  // ring bus layout
  // ----------------------------------------
  // parity outranks the others: a corrupt packet makes its other flags suspect
  bec_pkg::bec_pst_e  ring_pst;
  bec_pkg::bec_rsub_e ring_sub;
  assign ring_pst = ring_parity_err      ? bec_pkg::BEC_PST_PARITY :
                    ring_byte_enable_err ? bec_pkg::BEC_PST_NODEST :
                    ring_unclaimed       ? bec_pkg::BEC_PST_NODEST :
                    ring_endpoint_off    ? bec_pkg::BEC_PST_UNAVL  :
                                           bec_pkg::BEC_PST_OK;
  assign ring_sub = ring_parity_err      ? bec_pkg::BEC_RSUB_RING :
                    ring_byte_enable_err ? bec_pkg::BEC_RSUB_BYTE :
                                           bec_pkg::BEC_RSUB_RESP;

  bec_pkg::bec_detail_t ring_fmt;
  always_comb begin
    ring_fmt = '0;
    ring_fmt[`BEC_SUB_HI:`BEC_SUB_LO] = ring_sub;
    ring_fmt[`BEC_EXT_BIT]            = 1'b0;
    ring_fmt[`BEC_RW_BIT]             = ring_pkt_write;
    ring_fmt[`BEC_PST_HI:`BEC_PST_LO] = ring_pst;
  end

  assign detail_d = cap_ring ? ring_fmt : cap_unit ? unit_fmt : detail_q;

  // ----------------------------------------
  // axi4-lite write path
  // ----------------------------------------
  wire aw_take  = s_axi_awvalid && s_axi_awready;
  wire w_take   = s_axi_wvalid && s_axi_wready;
  wire aw_have  = aw_got_q || aw_take;
  wire w_have   = w_got_q || w_take;
  wire wr_fire  = aw_have && w_have && !bvalid_q;
  wire [7:0]  wr_addr = aw_got_q ? awaddr_q : s_axi_awaddr;
  wire [31:0] wr_data = w_got_q ? wdata_q : s_axi_wdata;
  wire [3:0]  wr_strb = w_got_q ? wstrb_q : s_axi_wstrb;
  wire wr_stat  = wr_fire && (wr_addr == `BEC_OFF_STATUS);
  wire wr_mask  = wr_fire && (wr_addr == `BEC_OFF_MASK);
  wire wr_ctrl  = wr_fire && (wr_addr == `BEC_OFF_CTRL);
  wire wr_ro    = (wr_addr == `BEC_OFF_DETAIL_LO) || (wr_addr == `BEC_OFF_DETAIL_HI) ||
                  (wr_addr == `BEC_OFF_TYPE);
  wire wr_hit   = wr_ro || (wr_addr == `BEC_OFF_STATUS) || (wr_addr == `BEC_OFF_MASK) ||
                  (wr_addr == `BEC_OFF_CTRL);
  wire [31:0] wr_ones  = lane_merge(32'h0000_0000, wr_data, wr_strb);
  wire [31:0] mask_mrg = lane_merge({30'h0, mask_q}, wr_data, wr_strb);
  wire [31:0] ctrl_mrg = lane_merge({31'h0, ctrl_q}, wr_data, wr_strb);

  assign s_axi_awready = !aw_got_q && !bvalid_q;
  assign s_axi_wready  = !w_got_q && !bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;

  // set wins over a same-cycle write-one clear
  wire [1:0] st_set = {cap_ring, cap_unit};
  assign status_d = (status_q & ~(wr_stat ? wr_ones[1:0] : 2'h0)) | st_set;
  assign mask_d   = wr_mask ? mask_mrg[1:0] : mask_q;
  assign ctrl_d   = wr_ctrl ? ctrl_mrg[0] : ctrl_q;

  // ----------------------------------------
  // axi4-lite read path
  // ----------------------------------------
  wire ar_take = s_axi_arvalid && s_axi_arready;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  logic [31:0] rd_mux;
  logic        rd_hit;
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `BEC_OFF_DETAIL_LO: rd_mux = detail_q[31:0];
      `BEC_OFF_DETAIL_HI: rd_mux = {6'h00, detail_q[57:32]};
      `BEC_OFF_TYPE:      rd_mux = {26'h0, type_q};
      `BEC_OFF_STATUS:    rd_mux = {30'h0, status_q};
      `BEC_OFF_MASK:      rd_mux = {30'h0, mask_q};
      `BEC_OFF_CTRL:      rd_mux = {31'h0, ctrl_q};
      default:            rd_hit = 1'b0;
    endcase
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      detail_q <= '0;
      type_q   <= 6'h00;
      status_q <= 2'h0;
      mask_q   <= `BEC_RST_MASK;
      ctrl_q   <= `BEC_RST_CTRL;
    end else begin
      detail_q <= detail_d;
      if (cap_unit || cap_ring) begin
        type_q <= err_type;
      end
      status_q <= status_d;
      mask_q   <= mask_d;
      ctrl_q   <= ctrl_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q <= 1'b0;
      w_got_q  <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q  <= 2'h0;
    end else begin
      if (aw_take && !wr_fire) begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (w_take && !wr_fire) begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_got_q <= 1'b0;
        w_got_q  <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q  <= wr_hit ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= 2'h0;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_mux;
      rresp_q  <= rd_hit ? 2'h0 : 2'h2;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // level interrupt from unmasked sticky bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_d & mask_d);
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_unit_subcode: assert property (
    cap_unit |=> detail_q[57:54] == $past(unit_subcode))
    else $error("bus unit subcode not captured");

  chk_axi_id_gate: assert property (
    cap_unit |=> detail_q[48:41] == ((is_axi_sub($past(unit_subcode)) &&
      $past(err_type) == 6'h08) ? $past(unit_axi_id) : 8'h00))
    else $error("axi id gating wrong");

  chk_resp_gate: assert property (
    cap_unit |=> detail_q[40:37] == ((is_axi_sub($past(unit_subcode)) &&
      $past(err_type) == 6'h08) ? $past(unit_axi_resp) : 4'h0))
    else $error("response captured for wrong subcode");

  chk_rdb_fields: assert property (
    cap_unit && rdb_ok |=> detail_q[36:24] == $past({unit_entry_lock, requesting_thread_number,
      unit_req_port, unit_entry_write, unit_entry_uca, entry_uncached_flag}))
    else $error("request buffer fields wrong");

  chk_rdb_zero: assert property (
    cap_unit && !rdb_ok |=> detail_q[36:24] == 13'h0 && detail_q[53:49] == 5'h0)
    else $error("invalid fields not zero");

  chk_ring_fmt: assert property (
    cap_ring |=> !detail_q[47] && detail_q[46] == $past(ring_pkt_write) &&
      detail_q[43:0] == 44'h0 && detail_q[53:48] == 6'h0)
    else $error("ring layout wrong");

  chk_ring_parity: assert property (
    cap_ring && ring_parity_err |=> detail_q[45:44] == 2'h3 && detail_q[57:54] == 4'h2)
    else $error("parity status wrong");

  chk_ring_status: assert property (
    cap_ring && !ring_parity_err |=> detail_q[45:44] ==
      ($past(ring_byte_enable_err || ring_unclaimed) ? 2'h2 :
       $past(ring_endpoint_off) ? 2'h1 : 2'h0))
    else $error("ring status code wrong");

  chk_irq_level: assert property (
    irq == ((status_q & mask_q) != 2'h0))
    else $error("irq level wrong");

  chk_bresp_order: assert property (
    wr_fire |=> s_axi_bvalid [*1] ##0 !s_axi_awready)
    else $error("write response late");

  chk_ring_subcode: assert property (
    cap_ring && !ring_parity_err |=> detail_q[57:54] ==
      ($past(ring_byte_enable_err) ? 4'h3 : 4'h1))
    else $error("ring subcode wrong");

  chk_type_capture: assert property (
    cap_unit || cap_ring |=> type_q == $past(err_type))
    else $error("error type not captured");

  chk_detail_hold: assert property (
    !cap_unit && !cap_ring |=> detail_q == $past(detail_q))
    else $error("detail changed without capture");

  chk_ctrl_refuse: assert property (
    err_valid && !ctrl_q |=> type_q == $past(type_q))
    else $error("capture while disabled");

  // a capture must survive a write-one clear in the same cycle
  chk_status_set: assert property (
    cap_unit || cap_ring |=> (status_q & $past({cap_ring, cap_unit})) ==
      $past({cap_ring, cap_unit}))
    else $error("status set lost");

  chk_read_answer: assert property (
    ar_take |=> s_axi_rvalid)
    else $error("read answer missing");

  chk_write_clear: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response stuck");

  chk_read_clear: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data stuck");

  cov_unit_axi: cover property (cap_unit && axi_ok ##[1:8] s_axi_rvalid);
  cov_ring_par: cover property (cap_ring && ring_parity_err);
  cov_irq_clear: cover property (irq ##[1:20] !irq);
  cov_masked_hold: cover property (status_q != 2'h0 && !irq);
endmodule : bec_capture

//--- design/bec_cfg.svh
`ifndef BEC_CFG_SVH
`define BEC_CFG_SVH
// ----------------------------------------
// register map, byte addresses
// ----------------------------------------
`define BEC_OFF_DETAIL_LO 8'h00
`define BEC_OFF_DETAIL_HI 8'h04
`define BEC_OFF_TYPE      8'h08
`define BEC_OFF_STATUS    8'h0C
`define BEC_OFF_MASK      8'h10
`define BEC_OFF_CTRL      8'h14
// ----------------------------------------
// reset values
// ----------------------------------------
`define BEC_RST_CTRL      1'h1
`define BEC_RST_MASK      2'h0
// ----------------------------------------
// error types and detail layout
// ----------------------------------------
`define BEC_TYPE_UNIT_LO  6'h06
`define BEC_TYPE_UNIT_HI  6'h08
`define BEC_TYPE_AXI_CAP  6'h08
`define BEC_TYPE_RING     6'h0A
`define BEC_SUB_HI        57
`define BEC_SUB_LO        54
`define BEC_AXID_HI       48
`define BEC_AXID_LO       41
`define BEC_RESP_HI       40
`define BEC_RESP_LO       37
`define BEC_LOCK_BIT      36
`define BEC_THRD_HI       35
`define BEC_THRD_LO       31
`define BEC_PORT_HI       30
`define BEC_PORT_LO       27
`define BEC_WR_BIT        26
`define BEC_UCA_BIT       25
`define BEC_UC_BIT        24
`define BEC_EXT_BIT       47
`define BEC_RW_BIT        46
`define BEC_PST_HI        45
`define BEC_PST_LO        44
// ----------------------------------------
// status bit positions
// ----------------------------------------
`define BEC_ST_UNIT       0
`define BEC_ST_RING       1
`endif

//--- design/bec_pkg.sv
package bec_pkg;
  typedef logic [57:0] bec_detail_t;
  typedef enum logic [1:0] {
    BEC_PST_OK     = 2'h0,
    BEC_PST_UNAVL  = 2'h1,
    BEC_PST_NODEST = 2'h2,
    BEC_PST_PARITY = 2'h3
  } bec_pst_e;
  typedef enum logic [3:0] {
    BEC_RSUB_RSVD  = 4'h0,
    BEC_RSUB_RESP  = 4'h1,
    BEC_RSUB_RING  = 4'h2,
    BEC_RSUB_BYTE  = 4'h3
  } bec_rsub_e;
endpackage : bec_pkg

//--- verif/bec_capture_tb.sv
`timescale 1ns/1ns
`include "bec_cfg.svh"
module bec_capture_tb;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic        aclk, aresetn, irq, err_valid;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, unit_axi_id;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd, rnd;
  logic [3:0]  s_axi_wstrb, unit_subcode, unit_axi_resp, unit_req_port;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        unit_entry_lock, unit_entry_write, unit_entry_uca, entry_uncached_flag;
  logic [5:0]  err_type;
  logic [4:0]  requesting_thread_number;
  logic        ring_pkt_write, ring_endpoint_off, ring_unclaimed, ring_byte_enable_err;
  logic        ring_parity_err;
  logic [57:0] exp_det;
  int          error_cnt, check_count, seed;

  bec_capture dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .err_valid, .err_type, .unit_subcode, .unit_axi_id, .unit_axi_resp,
    .unit_entry_lock, .requesting_thread_number, .unit_req_port, .unit_entry_write,
    .unit_entry_uca, .entry_uncached_flag, .ring_pkt_write, .ring_endpoint_off,
    .ring_unclaimed, .ring_byte_enable_err, .ring_parity_err, .irq
  );

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // ----------------------------------------
  // checking and bus tasks
  // ----------------------------------------
  task print_verdict;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task timeout;
    error_cnt++;
    $display("BAD handshake expected answer seen none");
    print_verdict();
  endtask : timeout

  // bready raised with the request: the slave answers when both halves are held
  task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 50);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n >= 50) timeout();
  endtask : axi_wr

  task axi_rd(input logic [7:0] a);
    int n;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 50);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n >= 50) timeout();
  endtask : axi_rd

  function automatic logic [57:0] exp_detail();
    logic [57:0] v;
    logic [3:0]  s;
    s = unit_subcode;
    v = '0;
    if (err_type == 6'h0A) begin
      v[57:54] = ring_parity_err ? 4'h2 : ring_byte_enable_err ? 4'h3 : 4'h1;
      v[46] = ring_pkt_write;
      v[45:44] = ring_parity_err ? 2'h3 : (ring_byte_enable_err | ring_unclaimed) ? 2'h2 :
                 ring_endpoint_off ? 2'h1 : 2'h0;
    end else begin
      v[57:54] = s;
      if (err_type == 6'h08 && s inside {4'h1, 4'h3, 4'h4, 4'h5}) begin
        v[48:41] = unit_axi_id;
        v[40:37] = unit_axi_resp;
      end
      if (s inside {4'h0, 4'h1, 4'h2, 4'h3, 4'h6, 4'h8, 4'h9})
        v[36:24] = {unit_entry_lock, requesting_thread_number, unit_req_port,
                    unit_entry_write, unit_entry_uca, entry_uncached_flag};
    end
    return v;
  endfunction : exp_detail

  // one-cycle error pulse; details stay put afterwards so the expectation can read them
  task inject(input logic [5:0] t, input logic [3:0] s, input logic [4:0] rf);
    @(posedge aclk);
    rnd = $random(seed);
    err_valid    <= 1'b1;
    err_type     <= t;
    unit_subcode <= s;
    {unit_axi_id, unit_axi_resp, requesting_thread_number, unit_req_port} <= rnd[20:0];
    {unit_entry_lock, unit_entry_write, unit_entry_uca, entry_uncached_flag} <= rnd[24:21];
    {ring_pkt_write, ring_endpoint_off, ring_unclaimed, ring_byte_enable_err,
     ring_parity_err} <= rf;
    @(posedge aclk);
    err_valid <= 1'b0;
    exp_det = exp_detail();
  endtask : inject

  task check_cap(input logic [1:0] st, input logic [5:0] t);
    axi_rd(`BEC_OFF_DETAIL_LO);
    chk("detail_lo", exp_det[31:0], rd);
    axi_rd(`BEC_OFF_DETAIL_HI);
    chk("detail_hi", {6'h00, exp_det[57:32]}, rd);
    axi_rd(`BEC_OFF_TYPE);
    chk("type", {26'h0, t}, rd);
    axi_rd(`BEC_OFF_STATUS);
    chk("status", {30'h0, st}, rd);
    chk("irq", {31'h0, st != 2'h0}, {31'h0, irq});
    axi_wr(`BEC_OFF_STATUS, 32'hFFFF_FFFF, 4'hF);
    chk("irq_clr", 32'h0, {31'h0, irq});
  endtask : check_cap

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    seed = 32'hf917;
    error_cnt = 0;
    check_count = 0;
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready, err_valid, err_type} = '0;
    {unit_subcode, unit_axi_id, unit_axi_resp, unit_entry_lock, requesting_thread_number} = '0;
    {unit_req_port, unit_entry_write, unit_entry_uca, entry_uncached_flag} = '0;
    {ring_pkt_write, ring_endpoint_off, ring_unclaimed, ring_byte_enable_err} = '0;
    ring_parity_err = 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(`BEC_OFF_CTRL);
    chk("ctrl_rst", 32'h1, rd);
    axi_rd(`BEC_OFF_MASK);
    chk("mask_rst", 32'h0, rd);
    $display("test reset done");
    axi_wr(`BEC_OFF_MASK, 32'h3, 4'hF);
    for (int i = 0; i < 40; i++) begin
      rnd = $random(seed);
      inject(6'h06 + 6'(i % 3), (i < 16) ? i[3:0] : rnd[3:0], rnd[8:4]);
      check_cap(2'h1, 6'h06 + 6'(i % 3));
    end
    $display("test bus unit done");
    for (int j = 0; j < 32; j++) begin
      rnd = $random(seed);
      inject(6'h0A, rnd[3:0], j[4:0]);
      check_cap(2'h2, 6'h0A);
    end
    $display("test ring done");
    inject(6'h09, 4'h3, 5'h1F);
    inject(6'h05, 4'h1, 5'h00);
    axi_rd(`BEC_OFF_STATUS);
    chk("status_other", 32'h0, rd);
    axi_wr(`BEC_OFF_CTRL, 32'h0, 4'hF);
    inject(6'h08, 4'h3, 5'h00);
    axi_rd(`BEC_OFF_STATUS);
    chk("status_off", 32'h0, rd);
    axi_rd(`BEC_OFF_TYPE);
    chk("type_kept", 32'h0A, rd);
    axi_wr(`BEC_OFF_CTRL, 32'h1, 4'hF);
    $display("test refusal done");
    axi_wr(`BEC_OFF_MASK, 32'h2, 4'hF);
    axi_wr(`BEC_OFF_MASK, 32'h1, 4'h0);
    axi_rd(`BEC_OFF_MASK);
    chk("mask_strobe", 32'h2, rd);
    inject(6'h07, 4'h2, 5'h00);
    axi_rd(`BEC_OFF_STATUS);
    chk("status_masked", 32'h1, rd);
    chk("irq_masked", 32'h0, {31'h0, irq});
    inject(6'h0A, 4'h0, 5'h01);
    axi_rd(`BEC_OFF_STATUS);
    chk("status_both", 32'h3, rd);
    chk("irq_unmasked", 32'h1, {31'h0, irq});
    axi_wr(`BEC_OFF_STATUS, 32'h2, 4'hF);
    chk("irq_w1c", 32'h0, {31'h0, irq});
    $display("test interrupt done");
    axi_rd(8'h18);
    chk("rresp_unmapped", 32'h2, {30'h0, rsp});
    chk("rdata_unmapped", 32'h0, rd);
    axi_wr(8'h18, 32'hFFFF_FFFF, 4'hF);
    chk("bresp_unmapped", 32'h2, {30'h0, rsp});
    axi_wr(`BEC_OFF_TYPE, 32'h3F, 4'hF);
    chk("bresp_ro", 32'h0, {30'h0, rsp});
    axi_rd(`BEC_OFF_TYPE);
    chk("type_ro", 32'h0A, rd);
    $display("test bus map done");
    // reset in mid-run must clear captures and status but keep capture enabled
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(`BEC_OFF_STATUS);
    chk("status_rst", 32'h0, rd);
    axi_rd(`BEC_OFF_TYPE);
    chk("type_rst", 32'h0, rd);
    axi_rd(`BEC_OFF_DETAIL_HI);
    chk("detail_rst", 32'h0, rd);
    axi_rd(`BEC_OFF_CTRL);
    chk("ctrl_rst2", 32'h1, rd);
    chk("irq_rst", 32'h0, {31'h0, irq});
    $display("test second reset done");
    print_verdict();
  end
endmodule : bec_capture_tb
